// ===== src/sadc_top.sv
// Serial converter control: start detection, channel assignment, result stream
`timescale 1ns/1ps
// Operation
// - Sample input line on serial rising edge
// - First one is start, leading zeros ignored
// - Two assignment bits follow start bit
// - Kind one: single channel, polarity picks
// - Kind zero: differential, polarity swaps inputs
// - Single-channel variant skips assignment word
// - Half-clock settle, then input ignored
// - Leave high impedance, drive leading zero
// - Decisions out MSB first on falling edge
// - Eight decisions give the 8-bit code
// - Two-channel variant repeats result LSB first
// - Single-channel variant sends MSB first only
// - Output low until select returns high
// - Input sampled only while output floats
// - Select high: idle, output high impedance
// - Negative above positive gives all zeros
module sadc_top
    import sadc_pkg::*;
#(
    parameter bit TWO_CHAN = 1'b1   // Variant with channel assignment and repeat
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              cs_b,              // Chip select pin
    input  wire logic              sclk,              // Serial clock pin
    input  wire logic              serial_in_line,    // Serial data pin
    input  wire logic              comp_high,         // Comparator: input above trial
    input  wire logic              pos_below_neg,     // Front end: positive below negative
    output logic                   dout,              // Serial data out
    output logic                   dout_oe,           // Drive enable of data out
    output logic                   input_kind_select, // 1 single-ended, 0 differential
    output logic                   polarity_select,   // Channel or polarity choice
    output logic [DATA_W-1:0]      trial_code,        // Trial code to the ladder
    output logic                   sclk_too_fast      // Serial clock above limit seen
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SYNC_N-1:0] meta;       // First stage, read only by the second
    logic [SYNC_N-1:0] sync;       // Safe copies
    logic              sclk_d;     // Previous serial clock level
    logic              rise;       // Serial clock rising edge enable
    logic              fall;       // Serial clock falling edge enable
    logic              cs_s;
    logic              din_s;
    logic              cmp_eff;    // Comparator decision after polarity guard

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    meta[gi] <= SYNC_RST[gi];
                    sync[gi] <= SYNC_RST[gi];
                end else begin
                    meta[gi] <= (gi == PIN_CS)  ? cs_b :
                                (gi == PIN_CLK) ? sclk :
                                (gi == PIN_DIN) ? serial_in_line :
                                (gi == PIN_CMP) ? comp_high : pos_below_neg;
                    sync[gi] <= meta[gi];
                end
            end
        end
    endgenerate

    assign cs_s  = sync[PIN_CS];
    assign din_s = sync[PIN_DIN];
    assign rise  = sync[PIN_CLK] & ~sclk_d;
    assign fall  = ~sync[PIN_CLK] & sclk_d;
    assign cmp_eff = sync[PIN_CMP] & ~sync[PIN_NEG];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    sadc_state_e       state;
    sadc_state_e       next_state;
    logic [CNT_W-1:0]  cnt;         // Bit counter within a phase
    logic [CNT_W-1:0]  next_cnt;
    logic              next_dout;
    logic              next_oe;
    logic              next_kind;
    logic              next_pol;
    logic [GAP_W-1:0]  gap;         // System cycles since last rising edge
    logic [GAP_W-1:0]  next_gap;
    logic              next_fast;
    sadc_sar_if        sif ();

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_dout  = dout;
        next_oe    = dout_oe;
        next_kind  = input_kind_select;
        next_pol   = polarity_select;
        sif.clear  = 1'b0;
        sif.step   = 1'b0;
        sif.cmp    = cmp_eff;
        sif.load   = 1'b0;
        sif.shift  = 1'b0;
        if (cs_s) begin
            next_state = SADC_IDLE;
            next_cnt   = '0;
            next_dout  = 1'b0;
            next_oe    = 1'b0;
            sif.clear  = 1'b1;
        end else begin
            unique case (state)
                SADC_IDLE: begin
                    next_state = SADC_WAIT;
                end
                SADC_WAIT: begin
                    if (rise && din_s) begin
                        next_cnt  = '0;
                        sif.clear = 1'b1;
                        if (TWO_CHAN) begin
                            next_state = SADC_ADDR;
                        end else begin
                            next_state = SADC_SETTLE;
                            next_kind  = 1'b0;
                            next_pol   = 1'b0;
                        end
                    end
                end
                SADC_ADDR: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                        if (cnt == ADDR_LAST) begin
                            // polarity picks channel or swaps pair
                            next_pol   = din_s;
                            next_state = SADC_SETTLE;
                        end else begin
                            next_kind = din_s;
                        end
                    end
                end
                SADC_SETTLE: begin
                    // leave high impedance with leading zero
                    if (fall) begin
                        next_oe    = 1'b1;
                        next_dout  = 1'b0;
                        next_cnt   = '0;
                        next_state = SADC_CONV;
                    end
                end
                SADC_CONV: begin
                    // each decision out on falling edge, MSB first
                    if (fall) begin
                        sif.step  = 1'b1;
                        next_dout = cmp_eff;
                        next_cnt  = cnt + 4'h1;
                        if (cnt == CONV_LAST) begin
                            next_cnt = '0;
                            // repeat only on the two-channel variant
                            sif.load   = TWO_CHAN;
                            next_state = TWO_CHAN ? SADC_RPT : SADC_DONE;
                        end
                    end
                end
                SADC_RPT: begin
                    if (fall) begin
                        next_cnt = cnt + 4'h1;
                        if (cnt == RPT_LAST) begin
                            next_dout  = 1'b0;
                            next_state = SADC_DONE;
                        end else begin
                            next_dout = sif.shreg[0];
                            sif.shift = 1'b1;
                        end
                    end
                end
                SADC_DONE: begin
                    if (fall) begin
                        next_dout = 1'b0;
                    end
                end
                default: begin
                    next_state = SADC_IDLE;
                end
            endcase
        end
    end

    // Serial clock speed watch; host must keep below the limit
    always_comb begin
        next_gap  = rise ? '0 : (gap == GAP_W'(SCLK_MIN_CYC)) ? gap : gap + 8'h01;
        next_fast = sclk_too_fast;
        // flag rising edges closer than the limit
        if (state == SADC_IDLE) begin
            next_fast = 1'b0;
        end else if (rise && gap < GAP_W'(SCLK_MIN_CYC)) begin
            next_fast = 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state             <= SADC_IDLE;
            cnt               <= '0;
            dout              <= 1'b0;
            dout_oe           <= 1'b0;
            input_kind_select <= 1'b0;
            polarity_select   <= 1'b0;
            sclk_d            <= 1'b0;
            gap               <= GAP_W'(SCLK_MIN_CYC);  // Saturated: first edge of a frame is legal
            sclk_too_fast     <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            dout              <= next_dout;
            dout_oe           <= next_oe;
            input_kind_select <= next_kind;
            polarity_select   <= next_pol;
            sclk_d            <= sync[PIN_CLK];
            gap               <= next_gap;
            sclk_too_fast     <= next_fast;
        end
    end

    // Approximation engine; trial code leaves straight from its flop
    sadc_sar u_sar (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif.eng)
    );
    assign trial_code = sif.trial;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_settle_edge;
        state == SADC_SETTLE && fall && !cs_s;
    endsequence
    sequence s_conv_edge;
        state == SADC_CONV && fall && !cs_s;
    endsequence

    property p_deselect;
        @(posedge clk) disable iff (!rst_b)
        cs_s |=> (state == SADC_IDLE && !dout_oe);
    endproperty
    a_deselect: assert property (p_deselect) else $error("select high not idle");

    property p_zero_skip;
        @(posedge clk) disable iff (!rst_b)
        (state == SADC_WAIT && rise && !din_s && !cs_s) |=> state == SADC_WAIT;
    endproperty
    a_zero_skip: assert property (p_zero_skip) else $error("leading zero taken");

    property p_start;
        @(posedge clk) disable iff (!rst_b)
        (state == SADC_WAIT && rise && din_s && !cs_s) |=>
            state == (TWO_CHAN ? SADC_ADDR : SADC_SETTLE);
    endproperty
    a_start: assert property (p_start) else $error("start bit missed");

    property p_lead_zero;
        @(posedge clk) disable iff (!rst_b)
        s_settle_edge |=> (dout_oe && !dout && state == SADC_CONV);
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("no leading zero");

    property p_float_addr;
        @(posedge clk) disable iff (!rst_b)
        (state == SADC_WAIT || state == SADC_ADDR) |-> !dout_oe;
    endproperty
    a_float_addr: assert property (p_float_addr) else $error("driven while addressing");

    property p_msb_bit;
        @(posedge clk) disable iff (!rst_b)
        s_conv_edge |=> (dout == $past(cmp_eff) && dout_oe);
    endproperty
    a_msb_bit: assert property (p_msb_bit) else $error("decision not shown");

    property p_conv_len;
        @(posedge clk) disable iff (!rst_b)
        (s_conv_edge and (cnt == CONV_LAST)) |=>
            state == (TWO_CHAN ? SADC_RPT : SADC_DONE);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("wrong decision count");

    property p_ignore_in;
        @(posedge clk) disable iff (!rst_b)
        (state == SADC_CONV && !cs_s) |=>
            ($stable(input_kind_select) && $stable(polarity_select));
    endproperty
    a_ignore_in: assert property (p_ignore_in) else $error("input read in conversion");

    property p_done_low;
        @(posedge clk) disable iff (!rst_b)
        (state == SADC_DONE && !cs_s) |=> (!dout && dout_oe);
    endproperty
    a_done_low: assert property (p_done_low) else $error("output not low after result");
endmodule // sadc_top

// ===== src/sadc_pkg.sv
// Shared constants and types for the serial converter control block
package sadc_pkg;
    localparam int DATA_W             = 8;     // Result width in bits
    localparam int CNT_W              = 4;     // Bit counter width
    localparam int CLK_PERIOD_NS      = 4;     // System clock period
    localparam int SCLK_MIN_PERIOD_NS = 500;   // Fastest legal serial clock period
    // Least serial clock period in system cycles, rounded up
    localparam int SCLK_MIN_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W              = 8;     // Width of the edge gap counter
    localparam logic [CNT_W-1:0] ADDR_LAST = 4'h1;  // Second assignment bit
    localparam logic [CNT_W-1:0] CONV_LAST = 4'h7;  // Eighth decision
    localparam logic [CNT_W-1:0] RPT_LAST  = 4'h7;  // Count ending the reversed stream
    // Pin synchroniser order and reset values (select reset high)
    localparam int SYNC_N  = 5;
    localparam int PIN_CS  = 0;
    localparam int PIN_CLK = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_CMP = 3;
    localparam int PIN_NEG = 4;
    localparam logic [SYNC_N-1:0] SYNC_RST = 5'h01;
    localparam logic [DATA_W-1:0] TRIAL_RST = 8'h80;  // First trial: MSB set
    localparam logic [2:0]        IDX_RST   = 3'h7;

    // Sequencer states, Gray coded along the two-channel conversion path
    typedef enum logic [2:0] {
        SADC_IDLE   = 3'b000,
        SADC_WAIT   = 3'b001,
        SADC_ADDR   = 3'b011,
        SADC_SETTLE = 3'b010,
        SADC_CONV   = 3'b110,
        SADC_RPT    = 3'b111,
        SADC_DONE   = 3'b101
    } sadc_state_e;
endpackage

// ===== src/sadc_sar_if.sv
// Carrier between the sequencer and the approximation engine
`timescale 1ns/1ps
interface sadc_sar_if;
    import sadc_pkg::*;
    logic              clear;   // Restart approximation
    logic              step;    // Take one comparator decision
    logic              cmp;     // Decision bit
    logic              load;    // Copy result into output shifter
    logic              shift;   // Advance output shifter
    logic [DATA_W-1:0] code;    // Decided bits
    logic [DATA_W-1:0] trial;   // Trial code for the comparator ladder
    logic [DATA_W-1:0] shreg;   // Reversed-order output shifter
    modport ctrl (output clear, step, cmp, load, shift, input code, trial, shreg);
    modport eng  (input clear, step, cmp, load, shift, output code, trial, shreg);
endinterface

// ===== src/sadc_sar.sv
// Successive approximation register and reversed-order output shifter
`timescale 1ns/1ps
module sadc_sar
    import sadc_pkg::*;
(
    input wire logic  clk,
    input wire logic  rst_b,
    sadc_sar_if.eng   sif
);
    logic [2:0]        idx;        // Bit under decision
    logic [2:0]        next_idx;
    logic [DATA_W-1:0] next_code;
    logic [DATA_W-1:0] next_trial;
    logic [DATA_W-1:0] next_shreg;
    logic [DATA_W-1:0] code_r;
    logic [DATA_W-1:0] trial_r;
    logic [DATA_W-1:0] shreg_r;

    assign sif.code  = code_r;
    assign sif.trial = trial_r;
    assign sif.shreg = shreg_r;

    ////////////////////////////////////////////////////////////////////////
    // Next state of the engine
    always_comb begin
        next_idx   = idx;
        next_code  = code_r;
        next_trial = trial_r;
        next_shreg = shreg_r;
        if (sif.clear) begin
            // Fresh conversion, also used on abort
            next_idx   = IDX_RST;
            next_code  = '0;
            next_trial = TRIAL_RST;
            next_shreg = '0;
        end else if (sif.step) begin
            // Keep the trial bit only if the input stood above it
            next_code      = trial_r;
            next_code[idx] = sif.cmp;
            next_trial     = next_code;
            if (idx != 3'h0) begin
                next_trial[idx - 3'h1] = 1'b1;
            end
            next_idx = idx - 3'h1;
            if (sif.load) begin
                // LSB already left on the MSB stream, so start one bit up
                next_shreg = next_code >> 1;
            end
        end else if (sif.shift) begin
            next_shreg = shreg_r >> 1;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idx     <= IDX_RST;
            code_r  <= '0;
            trial_r <= TRIAL_RST;
            shreg_r <= '0;
        end else begin
            idx     <= next_idx;
            code_r  <= next_code;
            trial_r <= next_trial;
            shreg_r <= next_shreg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_load_copy;
        @(posedge clk) disable iff (!rst_b)
        (sif.step && sif.load && !sif.clear) |=> (shreg_r == (code_r >> 1));
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("shifter not loaded");
endmodule // sadc_sar

// ===== verification/sadc_host.sv
// Host-side model: select, serial clock, data line and the comparator front end
`timescale 1ns/1ps
module sadc_host (
    input  wire logic                       clk,
    output logic                            cs_b,
    output logic                            sclk,
    output logic                            serial_in_line,
    output logic                            comp_high,
    output logic                            pos_below_neg,
    input  wire logic                       dout,
    input  wire logic                       dout_oe,
    input  wire logic [sadc_pkg::DATA_W-1:0] trial_code
);
    import sadc_pkg::*;
    logic [DATA_W-1:0] target;  // Analog input as its ideal code
    logic              below;   // Negative input above positive

    // Comparator: input at or above the trial keeps the bit
    always @(negedge clk) begin
        comp_high     <= (target >= trial_code);
        pos_below_neg <= below;
    end

    // Idle pins; serial clock stands low outside frames
    initial begin
        cs_b           = 1'b1;
        sclk           = 1'b0;
        serial_in_line = 1'b0;
        comp_high      = 1'b0;
        pos_below_neg  = 1'b0;
        target         = 8'h00;
        below          = 1'b0;
    end

    // One frame; dout is sampled at each rising serial edge, mid-way in its bit
    task automatic run(input int zeros, input logic [1:0] addr, input int nrise,
                       input int half, output logic [39:0] d, output logic [39:0] oe);
        int i;
        d  = 40'h0;
        oe = 40'h0;
        cs_b = 1'b0;
        repeat (4) @(negedge clk);
        for (i = 0; i < nrise; i++) begin
            // start then assignment; later bits are junk the device must ignore
            serial_in_line = (i < zeros) ? 1'b0 : (i == zeros) ? 1'b1 :
                             (i == zeros + 1) ? addr[1] : (i == zeros + 2) ? addr[0] : i[0];
            repeat (4) @(negedge clk);
            sclk  = 1'b1;
            d[i]  = dout;
            oe[i] = dout_oe;
            // half period sets the serial rate
            repeat (half) @(negedge clk);
            sclk = 1'b0;
            repeat (half) @(negedge clk);
        end
    endtask

    // Deselect; data line turned round so a stale value never matches by luck
    task automatic deselect();
        cs_b           = 1'b1;
        serial_in_line = ~serial_in_line;
        repeat (8) @(negedge clk);
    endtask
endmodule // sadc_host

// ===== verification/sadc_bench.sv
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module sadc_bench;
    import sadc_pkg::*;
    logic              clk;
    logic              rst_b;
    int                fail_count;
    int                checks;
    logic [39:0]       d;
    logic [39:0]       oe;
    // Two-channel instance pins
    logic              cs_b, sclk, sin, cmp, neg, dout, dout_oe, kind, pol, fast;
    logic [DATA_W-1:0] trial;
    // Single-channel instance pins
    logic              cs_b1, sclk1, sin1, cmp1, neg1, dout1, dout_oe1, kind1, pol1, fast1;
    logic [DATA_W-1:0] trial1;

    sadc_top #(.TWO_CHAN(1'b1)) dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
        .serial_in_line(sin), .comp_high(cmp), .pos_below_neg(neg), .dout(dout),
        .dout_oe(dout_oe), .input_kind_select(kind), .polarity_select(pol),
        .trial_code(trial), .sclk_too_fast(fast));
    sadc_host h0 (.clk(clk), .cs_b(cs_b), .sclk(sclk), .serial_in_line(sin), .comp_high(cmp),
        .pos_below_neg(neg), .dout(dout), .dout_oe(dout_oe), .trial_code(trial));
    sadc_top #(.TWO_CHAN(1'b0)) dut_single (.clk(clk), .rst_b(rst_b), .cs_b(cs_b1),
        .sclk(sclk1), .serial_in_line(sin1), .comp_high(cmp1), .pos_below_neg(neg1),
        .dout(dout1), .dout_oe(dout_oe1), .input_kind_select(kind1),
        .polarity_select(pol1), .trial_code(trial1), .sclk_too_fast(fast1));
    sadc_host h1 (.clk(clk), .cs_b(cs_b1), .sclk(sclk1), .serial_in_line(sin1),
        .comp_high(cmp1), .pos_below_neg(neg1), .dout(dout1), .dout_oe(dout_oe1),
        .trial_code(trial1));

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bit j counted from the leading zero slot (j = 0): MSB stream, optional LSB-first repeat, then low
    function automatic logic exp_bit(int j, logic [7:0] c, bit two);
        if (j == 0) return 1'b0;
        if (j <= 8) return c[8-j];
        if (two && j <= 15) return c[j-8];
        return 1'b0;
    endfunction

    // Judge a captured frame: a = assignment bits after the start bit
    task automatic judge(input logic [39:0] dd, input logic [39:0] oo, input int z,
                         input int a, input logic [7:0] c, input bit two, input int n);
        int i;
        int j;
        for (i = 0; i < n; i++) begin
            j = i - (z + a + 1);
            chk("data enable", {7'h0, j >= 0}, {7'h0, oo[i]});
            if (j >= 0) begin
                chk("data bit", {7'h0, exp_bit(j, c, two)}, {7'h0, dd[i]});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        @(negedge clk);
        chk("enable after reset", 8'h00, {7'h0, dout_oe});
        chk("trial after reset", 8'h80, trial);
        chk("flag after reset", 8'h00, {7'h0, fast});
        $display("Test reset done");
    endtask

    // Every assignment code, different leading-zero counts and codes
    task automatic t_modes();
        logic [1:0] code [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
        logic [7:0] val  [4] = '{8'hA5, 8'h3C, 8'h01, 8'hFE};
        int m;
        for (m = 0; m < 4; m++) begin
            h0.target = val[m];
            h0.run(m, code[m], m + 22, 64, d, oe);
            judge(d, oe, m, 2, val[m], 1'b1, m + 22);
            chk("kind", {7'h0, code[m][1]}, {7'h0, kind});
            chk("polarity", {7'h0, code[m][0]}, {7'h0, pol});
            chk("rate flag", 8'h00, {7'h0, fast});
            h0.deselect();
            chk("enable idle", 8'h00, {7'h0, dout_oe});
        end
        $display("Test modes done");
    endtask

    // Front end reports reversed inputs: code must be all zeros
    task automatic t_below();
        h0.target = 8'hFF;
        h0.below  = 1'b1;
        h0.run(0, 2'b00, 22, 64, d, oe);
        judge(d, oe, 0, 2, 8'h00, 1'b1, 22);
        h0.below = 1'b0;
        h0.deselect();
        $display("Test below done");
    endtask

    // Select released mid-conversion, then a clean frame must follow
    task automatic t_abort();
        h0.target = 8'hC3;
        h0.run(0, 2'b10, 8, 64, d, oe);
        h0.deselect();
        chk("enable after abort", 8'h00, {7'h0, dout_oe});
        chk("trial after abort", 8'h80, trial);
        h0.target = 8'h69;
        h0.run(1, 2'b01, 23, 64, d, oe);
        judge(d, oe, 1, 2, 8'h69, 1'b1, 23);
        h0.deselect();
        $display("Test abort done");
    endtask

    // Serial clock faster than allowed raises the flag; idle clears it
    task automatic t_fast();
        h0.run(0, 2'b10, 6, 28, d, oe);
        chk("rate flag set", 8'h01, {7'h0, fast});
        h0.deselect();
        chk("rate flag idle", 8'h00, {7'h0, fast});
        $display("Test fast done");
    endtask

    // Single-channel variant: no assignment word, no repeat
    task automatic t_single();
        h1.target = 8'h5A;
        h1.run(1, 2'b11, 14, 64, d, oe);
        judge(d, oe, 1, 0, 8'h5A, 1'b0, 14);
        chk("single kind", 8'h00, {7'h0, kind1});
        chk("single polarity", 8'h00, {7'h0, pol1});
        chk("single rate flag", 8'h00, {7'h0, fast1});
        h1.deselect();
        chk("single enable idle", 8'h00, {7'h0, dout_oe1});
        chk("single trial idle", 8'h80, trial1);
        $display("Test single done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 22k cycles
    initial begin
        #300000;
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        conclude();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        checks     = 0;
        rst_b      = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_modes();
        t_below();
        t_abort();
        t_fast();
        t_single();
        conclude();
    end
endmodule // sadc_bench
